// ===== core/pho_freq_mon.sv
module pho_freq_mon (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        edge_in,
  input  wire logic [15:0] thresh,
  output logic             below
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] gap;    // cycles since the last input edge
    logic        below;  // input slower than the threshold
  } pho_mon_s;

  pho_mon_s mon_reg;
  pho_mon_s mon_next;

  // ----------------------------------------------------------------
  // gap counter; saturates so a dead input stays flagged
  // ----------------------------------------------------------------
  always_comb begin
    mon_next = mon_reg;
    if (edge_in) begin
      mon_next.gap   = 16'h0000;
      mon_next.below = 1'b0;  // any input edge clears the flag, however long the gap was
    end else begin
      if (mon_reg.gap != 16'hffff) begin
        mon_next.gap = mon_reg.gap + 16'h0001;
      end
      if (mon_reg.gap >= thresh) begin
        mon_next.below = 1'b1;
      end
    end
  end

  // register stage, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_reg <= '0;
    end else if (clk_en) begin
      mon_reg <= mon_next;
    end
  end

  assign below = mon_reg.below;

endmodule

// ===== core/pho_holdover.sv
module pho_holdover #(
  parameter logic [15:0] MON_NORM = pho_pkg::MON_NORM_CYC,
  parameter logic [15:0] MON_EXT  = pho_pkg::MON_EXT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sync_n,
  input  wire logic        ref_a_edge,
  input  wire logic        ref_b_edge,
  input  wire logic        vco_edge,
  input  wire logic        active_ref_second,
  input  wire logic        pfd_cycle,
  input  wire logic [7:0]  pfd_phase_err,
  input  wire logic        ana_lock,
  output logic             cp_tristate,
  output logic             swallow_reset,
  output logic [3:0]       chan_off,
  output logic             lock_pin,
  output logic             dig_locked,
  output logic [2:0]       freq_low,
  output logic             auto_switch_en,
  output logic             prefer_second,
  output logic [1:0]       ref_buf_en
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    pho_pkg::pho_hold_e hst;         // holdover sequencer
    logic               cp_tri;      // charge pump floated
    logic               swallow;     // one-cycle swallow counter reset
    logic               sync_prev;   // pin level one cycle ago
    logic [3:0]         chan_off;    // distribution outputs off
    logic [7:0]         lk_cnt;      // consecutive in-window cycles
    logic               dig;         // digital lock state
    logic [7:0]         charge;      // charged lock pin level
    logic               lock_pin;    // muxed lock indicator level
    logic [2:0]         freq_low;    // monitor flags, registered again
    logic [7:0]         lk_cfg;      // lock detect setup
    logic [7:0]         pin_ctrl;    // lock pin source
    logic [7:0]         ref_ctrl;    // reference control
    logic [7:0]         hold_ctrl;   // holdover control
    logic [7:0]         mon_thr;     // monitor threshold select
    logic [7:0]         charge_thr;  // charged pin trip count
    logic [3:0][7:0]    chan_cfg;    // channel divider controls
    logic               aw_got;      // write address held
    logic [9:0]         aw_idx;      // held write index
    logic               w_got;       // write data held
    logic [7:0]         wdata;       // held low byte
    logic               wstrb0;      // low byte lane enabled
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } pho_core_s;

  pho_core_s r_reg;
  pho_core_s r_next;
  logic [2:0] mon_below;    // raw monitor flags
  logic [2:0] mon_edges;    // edges fed to the monitors
  logic [2:0] mon_ext;      // extended threshold per monitor

  assign mon_edges = {vco_edge, ref_b_edge, ref_a_edge};
  // vco monitor has only the normal threshold
  assign mon_ext   = {1'b0, r_reg.mon_thr[1:0]};

  // ----------------------------------------------------------------
  // frequency monitors, one per watched input
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < 3; gi++) begin : g_mon
    pho_freq_mon u_mon (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .edge_in (mon_edges[gi]),
      .thresh  (mon_ext[gi] ? MON_EXT : MON_NORM),
      .below   (mon_below[gi])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        ho_en;
    logic        manual;
    logic        cmp_en;
    logic        lk_sense;
    logic        sel_edge;
    logic        sync_fall;
    logic        trigger;
    logic        release_ok;
    logic [7:0]  need;
    logic [7:0]  lk_thr;
    logic [7:0]  unlk_thr;
    logic        pin_src;
    logic        wr_ok;
    logic        rd_ok;
    logic [7:0]  wbyte;
    logic [9:0]  ar_idx;
    logic [31:0] rword;
    r_next     = r_reg;
    ho_en      = r_reg.hold_ctrl[pho_pkg::HO_EN_BIT];
    manual     = r_reg.hold_ctrl[pho_pkg::HO_EXT_BIT];
    cmp_en     = r_reg.hold_ctrl[pho_pkg::HO_CMP_BIT];
    lk_sense   = cmp_en ? r_reg.lock_pin : 1'b1;
    sel_edge   = active_ref_second ? ref_b_edge : ref_a_edge;
    sync_fall  = r_reg.sync_prev & ~sync_n;
    trigger    = manual ? sync_fall : ~lk_sense;
    release_ok = sel_edge & (manual ? sync_n : 1'b1);
    need       = 8'h00;
    lk_thr     = 8'h00;
    unlk_thr   = 8'h00;
    pin_src    = 1'b0;
    wr_ok      = 1'b1;
    rd_ok      = 1'b1;
    wbyte      = 8'h00;
    ar_idx     = s_axi_araddr[11:2];
    rword      = 32'h0000_0000;
    r_next.sync_prev = sync_n;
    r_next.swallow   = 1'b0;
    r_next.freq_low  = mon_below;

    // channels not told to ignore the pin go dark while it is low
    for (int ci = 0; ci < 4; ci++) begin
      r_next.chan_off[ci] = ~sync_n & ~r_reg.chan_cfg[ci][pho_pkg::CH_IGN_BIT];
    end

    // digital lock detector, evaluated once per phase comparison
    case (r_reg.lk_cfg[pho_pkg::LK_CNT_LSB +: 2])
      2'h0:    need = pho_pkg::LK_CYC0;
      2'h1:    need = pho_pkg::LK_CYC1;
      2'h2:    need = pho_pkg::LK_CYC2;
      default: need = pho_pkg::LK_CYC3;
    endcase
    if (!r_reg.lk_cfg[pho_pkg::LK_WIN_BIT]) begin
      lk_thr   = pho_pkg::LOCK_THR_HI;
      unlk_thr = pho_pkg::UNLOCK_THR_HI;
    end else begin
      lk_thr   = pho_pkg::LOCK_THR_LO;
      unlk_thr = pho_pkg::UNLOCK_THR_LO;
    end
    if (r_reg.lk_cfg[pho_pkg::LK_DIS_BIT]) begin
      r_next.dig    = 1'b0;
      r_next.lk_cnt = 8'h00;
    end else if (pfd_cycle) begin
      if (r_reg.dig) begin
        // the wider unlock window keeps the flag from chattering
        if (pfd_phase_err > unlk_thr) begin
          r_next.dig    = 1'b0;
          r_next.lk_cnt = 8'h00;
        end
      end else if (pfd_phase_err <= lk_thr) begin
        r_next.lk_cnt = r_reg.lk_cnt + 8'h01;
        if (r_reg.lk_cnt + 8'h01 >= need) begin
          r_next.dig = 1'b1;
        end
      end else begin
        r_next.lk_cnt = 8'h00;  // a miss restarts the count
      end
    end

    // charged lock pin: any lock dropout empties it at once
    if (!r_reg.dig) begin
      r_next.charge = 8'h00;
    end else if (r_reg.charge != 8'hff) begin
      r_next.charge = r_reg.charge + 8'h01;
    end

    // lock pin source select; unknown patterns read low
    case (r_reg.pin_ctrl[5:0])
      pho_pkg::PIN_CHARGED: pin_src = (r_reg.charge >= r_reg.charge_thr);
      pho_pkg::PIN_DIG:     pin_src = r_reg.dig;
      pho_pkg::PIN_ANA:     pin_src = ana_lock;
      default:              pin_src = 1'b0;
    endcase
    r_next.lock_pin = pin_src;

    // holdover sequencer
    case (r_reg.hst)
      pho_pkg::HS_RUN: begin
        if (ho_en && trigger) begin
          r_next.cp_tri = 1'b1;
          r_next.hst    = pho_pkg::HS_HOLD;
        end
      end
      pho_pkg::HS_HOLD: begin
        // without a reference edge the pump stays floated unless the holdover enable is cleared
        if (release_ok) begin
          r_next.cp_tri  = 1'b0;
          r_next.swallow = 1'b1;
          r_next.hst     = (!manual && cmp_en) ? pho_pkg::HS_REARM : pho_pkg::HS_RUN;
        end
      end
      pho_pkg::HS_REARM: begin
        // lock must come back before automatic entry is armed again
        if (manual || lk_sense) begin
          r_next.hst = pho_pkg::HS_RUN;
        end
      end
      default: begin
        r_next.hst    = pho_pkg::HS_RUN;
        r_next.cp_tri = 1'b0;
      end
    endcase
    if (!ho_en) begin
      r_next.hst    = pho_pkg::HS_RUN;
      r_next.cp_tri = 1'b0;
    end

    // register bus: write address and data, taken in either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got  = 1'b1;
      r_next.wdata  = s_axi_wdata[7:0];
      r_next.wstrb0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      wbyte = r_reg.wdata;
      case (r_reg.aw_idx)
        pho_pkg::IDX_LOCK_CFG:   if (r_reg.wstrb0) r_next.lk_cfg = wbyte & pho_pkg::LK_MASK;
        pho_pkg::IDX_PIN_CTRL:   if (r_reg.wstrb0) r_next.pin_ctrl = wbyte & pho_pkg::PIN_MASK;
        pho_pkg::IDX_REF_CTRL:   if (r_reg.wstrb0) r_next.ref_ctrl = wbyte & pho_pkg::RC_MASK;
        pho_pkg::IDX_HOLD_CTRL:  if (r_reg.wstrb0) r_next.hold_ctrl = wbyte & pho_pkg::HO_MASK;
        pho_pkg::IDX_MON_THR:    if (r_reg.wstrb0) r_next.mon_thr = wbyte & pho_pkg::MON_MASK;
        pho_pkg::IDX_CHARGE_THR: if (r_reg.wstrb0) r_next.charge_thr = wbyte;
        pho_pkg::IDX_CHAN0:      if (r_reg.wstrb0) r_next.chan_cfg[0] = wbyte & pho_pkg::CH_MASK;
        pho_pkg::IDX_CHAN1:      if (r_reg.wstrb0) r_next.chan_cfg[1] = wbyte & pho_pkg::CH_MASK;
        pho_pkg::IDX_CHAN2:      if (r_reg.wstrb0) r_next.chan_cfg[2] = wbyte & pho_pkg::CH_MASK;
        pho_pkg::IDX_CHAN3:      if (r_reg.wstrb0) r_next.chan_cfg[3] = wbyte & pho_pkg::CH_MASK;
        pho_pkg::IDX_STATUS:     wr_ok = 1'b1;  // read only, write ignored
        default:                 wr_ok = 1'b0;
      endcase
      r_next.bvalid = 1'b1;
      r_next.bresp  = wr_ok ? pho_pkg::RESP_OKAY : pho_pkg::RESP_SLVERR;
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
    end
    // channels close while a word is held or a response is owed
    r_next.awready = ~r_next.aw_got & ~r_next.bvalid;
    r_next.wready  = ~r_next.w_got & ~r_next.bvalid;

    // register bus: read, one outstanding at a time
    if (s_axi_rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      case (ar_idx)
        pho_pkg::IDX_LOCK_CFG:   rword = {24'h000000, r_reg.lk_cfg};
        pho_pkg::IDX_PIN_CTRL:   rword = {24'h000000, r_reg.pin_ctrl};
        pho_pkg::IDX_REF_CTRL:   rword = {24'h000000, r_reg.ref_ctrl};
        pho_pkg::IDX_HOLD_CTRL:  rword = {24'h000000, r_reg.hold_ctrl};
        pho_pkg::IDX_MON_THR:    rword = {24'h000000, r_reg.mon_thr};
        pho_pkg::IDX_CHARGE_THR: rword = {24'h000000, r_reg.charge_thr};
        pho_pkg::IDX_CHAN0:      rword = {24'h000000, r_reg.chan_cfg[0]};
        pho_pkg::IDX_CHAN1:      rword = {24'h000000, r_reg.chan_cfg[1]};
        pho_pkg::IDX_CHAN2:      rword = {24'h000000, r_reg.chan_cfg[2]};
        pho_pkg::IDX_CHAN3:      rword = {24'h000000, r_reg.chan_cfg[3]};
        pho_pkg::IDX_STATUS:     rword = {16'h0000, r_reg.charge, r_reg.freq_low,
                                          r_reg.hst == pho_pkg::HS_REARM, r_reg.lock_pin,
                                          r_reg.dig, r_reg.hst == pho_pkg::HS_HOLD,
                                          r_reg.cp_tri};
        default:                 rd_ok = 1'b0;
      endcase
      r_next.rvalid = 1'b1;
      r_next.rdata  = rword;
      r_next.rresp  = rd_ok ? pho_pkg::RESP_OKAY : pho_pkg::RESP_SLVERR;
    end
    r_next.arready = ~r_next.rvalid;
  end

  // ----------------------------------------------------------------
  // state register, frozen while the clock enable is low
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg            <= '0;
      r_reg.hst        <= pho_pkg::HS_RUN;
      r_reg.sync_prev  <= 1'b1;  // idle pin level avoids a false fall
      r_reg.lk_cfg     <= pho_pkg::CFG_RST;
      r_reg.pin_ctrl   <= pho_pkg::CFG_RST;
      r_reg.ref_ctrl   <= pho_pkg::CFG_RST;
      r_reg.hold_ctrl  <= pho_pkg::CFG_RST;
      r_reg.mon_thr    <= pho_pkg::CFG_RST;
      r_reg.charge_thr <= pho_pkg::CHARGE_THR_RST;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready  = r_reg.awready;
  assign s_axi_wready   = r_reg.wready;
  assign s_axi_bvalid   = r_reg.bvalid;
  assign s_axi_bresp    = r_reg.bresp;
  assign s_axi_arready  = r_reg.arready;
  assign s_axi_rvalid   = r_reg.rvalid;
  assign s_axi_rdata    = r_reg.rdata;
  assign s_axi_rresp    = r_reg.rresp;
  assign cp_tristate    = r_reg.cp_tri;
  assign swallow_reset  = r_reg.swallow;
  assign chan_off       = r_reg.chan_off;
  assign lock_pin       = r_reg.lock_pin;
  assign dig_locked     = r_reg.dig;
  assign freq_low       = r_reg.freq_low;
  assign auto_switch_en = r_reg.ref_ctrl[pho_pkg::RC_AUTO_BIT];
  assign prefer_second  = r_reg.ref_ctrl[pho_pkg::RC_PREF_BIT];
  assign ref_buf_en     = r_reg.ref_ctrl[pho_pkg::RC_BUF_LSB +: 2];

endmodule

// ===== core/pho_pkg.sv
package pho_pkg;

  // ----------------------------------------------------------------
  // register index map (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          IDX_W          = 10;
  localparam logic [9:0]  IDX_LOCK_CFG   = 10'h018;  // lock detect setup
  localparam logic [9:0]  IDX_PIN_CTRL   = 10'h01a;  // lock pin source select
  localparam logic [9:0]  IDX_REF_CTRL   = 10'h01c;  // reference control
  localparam logic [9:0]  IDX_HOLD_CTRL  = 10'h01d;  // holdover control
  localparam logic [9:0]  IDX_MON_THR    = 10'h01f;  // monitor threshold select
  localparam logic [9:0]  IDX_CHAN0      = 10'h191;  // channel divider 0 control
  localparam logic [9:0]  IDX_CHAN1      = 10'h194;  // channel divider 1 control
  localparam logic [9:0]  IDX_CHAN2      = 10'h197;  // channel divider 2 control
  localparam logic [9:0]  IDX_CHAN3      = 10'h19a;  // channel divider 3 control
  localparam logic [9:0]  IDX_STATUS     = 10'h1f0;  // live status, read only
  localparam logic [9:0]  IDX_CHARGE_THR = 10'h1f1;  // charged lock pin trip count

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LK_CNT_LSB  = 5;  // two-bit lock detect counter
  localparam int LK_WIN_BIT  = 4;  // window range, 0 = high range
  localparam int LK_DIS_BIT  = 3;  // digital lock detector disable
  localparam int HO_CMP_BIT  = 3;  // lock pin comparator enable
  localparam int HO_EXT_BIT  = 1;  // 1 = manual holdover from the pin
  localparam int HO_EN_BIT   = 0;  // holdover enable
  localparam int RC_AUTO_BIT = 4;  // automatic switchover enable
  localparam int RC_PREF_BIT = 3;  // 1 = prefer second reference
  localparam int RC_BUF_LSB  = 1;  // two reference buffer enables
  localparam int CH_IGN_BIT  = 6;  // channel ignores the resync pin

  // writable bits per register; the rest read as zero
  localparam logic [7:0] LK_MASK  = 8'h78;
  localparam logic [7:0] PIN_MASK = 8'h3f;
  localparam logic [7:0] RC_MASK  = 8'h1e;
  localparam logic [7:0] HO_MASK  = 8'h0b;
  localparam logic [7:0] MON_MASK = 8'h03;
  localparam logic [7:0] CH_MASK  = 8'h40;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [7:0] CHARGE_THR_RST = 8'h20;

  // ----------------------------------------------------------------
  // lock pin source encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] PIN_CHARGED = 6'h04;
  localparam logic [5:0] PIN_DIG     = 6'h01;
  localparam logic [5:0] PIN_ANA     = 6'h03;

  // ----------------------------------------------------------------
  // lock detector counts and phase windows
  // ----------------------------------------------------------------
  localparam logic [7:0] LK_CYC0       = 8'h05;  // encoding 00: five cycles
  localparam logic [7:0] LK_CYC1       = 8'h10;
  localparam logic [7:0] LK_CYC2       = 8'h40;
  localparam logic [7:0] LK_CYC3       = 8'hff;
  localparam logic [7:0] LOCK_THR_HI   = 8'h28;
  localparam logic [7:0] UNLOCK_THR_HI = 8'h50;
  localparam logic [7:0] LOCK_THR_LO   = 8'h0a;
  localparam logic [7:0] UNLOCK_THR_LO = 8'h14;

  // monitor thresholds in ref_clk cycles between input edges
  localparam logic [15:0] MON_NORM_CYC = 16'h0190;
  localparam logic [15:0] MON_EXT_CYC  = 16'h0fa0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // holdover sequencer
  typedef enum logic [2:0] {
    HS_RUN   = 3'h1,
    HS_HOLD  = 3'h2,
    HS_REARM = 3'h4
  } pho_hold_e;

endpackage

// ===== tb/pho_holdover_asserts.sv
// ------------------------------------------------
// holdover port checker
// ------------------------------------------------
module pho_holdover_asserts (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       sync_n,
  input wire logic       ref_a_edge,
  input wire logic       ref_b_edge,
  input wire logic       active_ref_second,
  input wire logic       pfd_cycle,
  input wire logic [7:0] pfd_phase_err,
  input wire logic       cp_tristate,
  input wire logic       swallow_reset,
  input wire logic [3:0] chan_off,
  input wire logic       lock_pin,
  input wire logic       dig_locked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // the swallow reset belongs to the release and nothing else
  AST_SWALLOW_AT_RELEASE: assert property (swallow_reset |-> $fell(cp_tristate))
    else $error("swallow pulse without pump release");
  AST_SWALLOW_ONE_CYCLE: assert property (swallow_reset |=> !swallow_reset)
    else $error("swallow pulse too long");
  AST_RELEASE_ON_REF: assert property (swallow_reset |-> ($past(active_ref_second) ?
    $past(ref_b_edge) : $past(ref_a_edge))) else $error("release without reference edge");
  // bench never clears the enable while floating, so only an edge ends it
  AST_FLOAT_HOLDS: assert property (cp_tristate && !ref_a_edge && !ref_b_edge
    |=> cp_tristate) else $error("pump released without reference edge");
  AST_ENTRY_CAUSE: assert property ($rose(cp_tristate) |-> !$past(sync_n) || !$past(lock_pin))
    else $error("pump floated without trigger");
  AST_CHAN_OFF_CAUSE: assert property (chan_off != 4'h0 |-> !$past(sync_n))
    else $error("channel off while pin high");
  AST_LOCK_DECLARE: assert property ($rose(dig_locked) |->
    $past(pfd_cycle) && $past(pfd_phase_err) <= 8'h28) else $error("lock without good cycle");
  AST_LOCK_KEEP: assert property (dig_locked && pfd_cycle && pfd_phase_err <= 8'h14
    |=> dig_locked) else $error("lock lost inside unlock window");
endmodule

bind pho_holdover pho_holdover_asserts pho_holdover_asserts_i (.ref_clk, .arst_n, .sync_n,
  .ref_a_edge, .ref_b_edge, .active_ref_second, .pfd_cycle, .pfd_phase_err, .cp_tristate,
  .swallow_reset, .chan_off, .lock_pin, .dig_locked);

// ===== tb/pho_holdover_tb_top.sv
module pho_holdover_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, arst_n = 1'h0, sync_n = 1'h1, active_ref_second = 1'h0;
  logic ref_run = 1'h1, err_big = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, ref_buf_en;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ref_a_edge, ref_b_edge, vco_edge, pfd_cycle, ana_lock, cp_tristate, swallow_reset;
  logic lock_pin, dig_locked, auto_switch_en, prefer_second;
  logic [7:0] pfd_phase_err, v;
  logic [3:0] chan_off;
  logic [2:0] freq_low;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  // short monitor limits keep the frequency tests brief
  pho_holdover #(.MON_NORM(16'h0028), .MON_EXT(16'h0050)) pho_holdover_i (.ref_clk, .arst_n,
    .clk_en(1'h1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_n, .ref_a_edge, .ref_b_edge, .vco_edge,
    .active_ref_second, .pfd_cycle, .pfd_phase_err, .ana_lock, .cp_tristate, .swallow_reset,
    .chan_off, .lock_pin, .dig_locked, .freq_low, .auto_switch_en, .prefer_second, .ref_buf_en);
  pho_ref_model pho_ref_model_i (.ref_clk, .arst_n, .ref_run, .err_big, .ref_a_edge,
    .ref_b_edge, .vco_edge, .pfd_cycle, .pfd_phase_err, .ana_lock);
  always #12.5 ref_clk = ~ref_clk;
  // expected switchover port image of a reference control value
  function automatic logic [31:0] ref_ports(input logic [7:0] d);
    return {28'h0, d[4], d[3], d[2:1]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one write, both channels offered together, each dropped at its own take
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic aw_p, w_p;
    aw_p = 1'h1;
    w_p = 1'h1;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw_p || w_p) begin
      @(posedge ref_clk);
      aw_p = aw_p && !s_axi_awready;
      w_p = w_p && !s_axi_wready;
      s_axi_awvalid <= aw_p;
      s_axi_wvalid <= w_p;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    chk(s_axi_bresp, pho_pkg::RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp,
                        input logic [1:0] er = pho_pkg::RESP_OKAY);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  task automatic print_verdict();
    $display("checked=%0d bad=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hang ends the run here
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h9d76242b));
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rd_chk(pho_pkg::IDX_CHARGE_THR, 32'h20);
    rd_chk(pho_pkg::IDX_HOLD_CTRL, 32'h0);
    rd_chk(10'h3ff, 32'h0, pho_pkg::RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h16 : 8'($urandom());
      wr(pho_pkg::IDX_REF_CTRL, v);
      rd_chk(pho_pkg::IDX_REF_CTRL, {24'h0, v & pho_pkg::RC_MASK});
      chk({auto_switch_en, prefer_second, ref_buf_en}, ref_ports(v));
    end
    $display("registers done");
    wr(pho_pkg::IDX_HOLD_CTRL, 8'h02);
    sync_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chk(cp_tristate, 1'h0);
    sync_n <= 1'h1;
    wr(pho_pkg::IDX_CHAN0, 8'h40);
    wr(pho_pkg::IDX_HOLD_CTRL, 8'h03);
    ref_run <= 1'h0;
    repeat (10) @(posedge ref_clk);
    sync_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk(cp_tristate, 1'h1);
    chk(chan_off, 4'he);
    sync_n <= 1'h1;
    repeat (20) @(posedge ref_clk);
    chk(cp_tristate, 1'h1);
    ref_run <= 1'h1;
    while (!swallow_reset) @(posedge ref_clk);
    chk(cp_tristate, 1'h0);
    $display("manual done");
    wr(pho_pkg::IDX_LOCK_CFG, 8'h00);
    wr(pho_pkg::IDX_PIN_CTRL, pho_pkg::PIN_CHARGED);
    wr(pho_pkg::IDX_CHARGE_THR, 8'h08);
    active_ref_second <= 1'h1;
    wr(pho_pkg::IDX_HOLD_CTRL, 8'h09);
    while (!lock_pin) @(posedge ref_clk);
    chk(dig_locked, 1'h1);
    err_big <= 1'h1;
    while (!cp_tristate) @(posedge ref_clk);
    chk({dig_locked, lock_pin}, 2'h0);
    err_big <= 1'h0;
    while (!swallow_reset) @(posedge ref_clk);
    repeat (16) @(posedge ref_clk);
    chk({cp_tristate, lock_pin}, 2'h0);
    $display("automatic done");
    wr(pho_pkg::IDX_HOLD_CTRL, 8'h01);
    err_big <= 1'h1;
    wr(pho_pkg::IDX_PIN_CTRL, pho_pkg::PIN_ANA);
    repeat (30) @(posedge ref_clk);
    chk({cp_tristate, lock_pin}, 2'h0);
    err_big <= 1'h0;
    wr(pho_pkg::IDX_PIN_CTRL, pho_pkg::PIN_DIG);
    repeat (60) @(posedge ref_clk);
    chk({lock_pin, dig_locked}, 2'h3);
    wr(pho_pkg::IDX_MON_THR, 8'h01);
    ref_run <= 1'h0;
    repeat (60) @(posedge ref_clk);
    chk(freq_low, 3'h2);
    ref_run <= 1'h1;
    repeat (20) @(posedge ref_clk);
    chk(freq_low, 3'h0);
    $display("monitors done");
    print_verdict();
  end
endmodule

// ===== tb/pho_ref_model.sv
// ------------------------------------------------
// reference, vco and phase detector source
// ------------------------------------------------
module pho_ref_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       ref_run,
  input  wire logic       err_big,
  output logic            ref_a_edge,
  output logic            ref_b_edge,
  output logic            vco_edge,
  output logic            pfd_cycle,
  output logic [7:0]      pfd_phase_err,
  output logic            ana_lock
);
  logic [2:0] ph;  // eight cycle reference period
  // refs stop when ref_run drops; the vco keeps running as in a real holdover
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph            <= 3'h0;
      ref_a_edge    <= 1'h0;
      ref_b_edge    <= 1'h0;
      vco_edge      <= 1'h0;
      pfd_cycle     <= 1'h0;
      pfd_phase_err <= 8'h0;
      ana_lock      <= 1'h0;
    end else begin
      ph            <= ph + 3'h1;
      ref_a_edge    <= ref_run && ph == 3'h0;
      ref_b_edge    <= ref_run && ph == 3'h3;
      vco_edge      <= ph[1:0] == 2'h1;
      pfd_cycle     <= ref_run && ph == 3'h0;
      // error value is redrawn every cycle while err_big is low (held at 8'hff while high), so nothing leans on a stale value
      pfd_phase_err <= err_big ? 8'hff : 8'($urandom_range(10, 0));
      ana_lock      <= !err_big;
    end
  end
endmodule
